// [verilog/interrupt_request_flags.sv]
`timescale 1ns/1ps
// How it works
// - timer-1 flag sits at bit 7 of timer_and_pin_irq_control and sets on timer 1 overflow.
// - timer-0 flag sits at bit 5 and sets on timer 0 overflow.
// - external-pin-one flag sits at bit 3 and sets on the P0.0 pin request.
// - external-pin-zero flag sits at bit 1 and sets on the P3.0 pin request.
// - writes of 1 to those four flags are ignored; only 0 clears them.
// - transmit-done sets at end of data bit 8 in mode 0, else at start of stop bit.
// - receive-done sets at end of data bit 8 in mode 0, else at middle of stop bit.
// - rx-done is bit 0 and tx-done bit 1 of serial control; hardware never clears them.
// - spi transfer-complete (bit 7 of spi_status) sets when a transfer finishes.
// - reading spi_status and then spi_data_register clears spi transfer-complete.
// - two-wire flag (bit 7 of two_wire_control) sets on entry to a protocol state.
// - entering idle state F8h does not set the two-wire flag.
// - two-wire flag clears only when software writes 0 to it.
// - writing 1 to the two-wire flag leaves it unchanged.
// - vectors: reset at 0, external zero at 0x0003, external two at 0x0083.
module interrupt_request_flags
  import irq_flags_pkg::*;
(
  input  wire logic                       mclk,          // 200 MHz system clock
  input  wire logic                       rst_b,         // async reset, active low
  input  wire logic [9:0]                 address,       // avalon word address
  input  wire logic                       read,          // avalon read
  input  wire logic                       write,         // avalon write
  input  wire logic [3:0]                 byteenable,    // avalon byte enables
  input  wire logic [31:0]                writedata,     // avalon write data
  output logic      [31:0]                readdata,      // avalon read data
  output logic                            waitrequest,   // avalon wait
  output logic      [1:0]                 response,      // 00 ok, 11 decode error
  input  irq_flags_pkg::event_t           events,        // peripheral events
  input  irq_flags_pkg::serial_mode_t     serialMode,    // uart mode
  input  wire logic [7:0]                 spiRxData,     // spi receive byte
  output logic      [irq_flags_pkg::NUM_SRC-1:0] cpuRequest, // per-source requests
  output logic      [15:0]                vectorAddr,    // vector of highest of ext0, t0, ext2 requests
  output logic                            irq            // masked summary interrupt
);
  import irq_flags_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  state_t st_r;
  state_t st_nxt;
  logic   hit;
  logic   wrEn;
  logic   rdEn;
  logic [7:0] idx;
  logic [7:0] wb;
  logic [NUM_SRC-1:0] srcEvt;
  logic   rdCap;
  logic   selTimerCtl;
  logic   selTwoWire;
  logic   selSpiStatus;
  logic   selSpiData;
  logic   selSerialCtl;
  logic   selIrqStatus;
  logic   selIrqMask;
  logic   selVector;

  // a flag that software may clear by writing 0; writes of 1 keep the value
  function automatic logic clr0Flag(input logic cur, input logic setEv,
                                    input logic wr, input logic wbit);
    logic v;
    v = cur;
    if (wr && !wbit) begin
      v = 1'b0;
    end
    if (setEv) begin
      v = 1'b1;
    end
    return v;
  endfunction

  function automatic logic isMapped(input logic [7:0] a);
    logic m;
    m = 1'b0;
    if (a == TIMER_AND_PIN_IRQ_CONTROL_IDX) begin
      m = 1'b1;
    end else if (a == TWO_WIRE_CONTROL_IDX) begin
      m = 1'b1;
    end else if (a == SPI_STATUS_IDX) begin
      m = 1'b1;
    end else if (a == SPI_DATA_REGISTER_IDX) begin
      m = 1'b1;
    end else if (a == SERIAL_PORT_CONTROL_IDX) begin
      m = 1'b1;
    end else if (a == IRQ_STATUS_IDX) begin
      m = 1'b1;
    end else if (a == IRQ_MASK_IDX) begin
      m = 1'b1;
    end else if (a == VECTOR_IDX) begin
      m = 1'b1;
    end
    return m;
  endfunction

  // value that a read of one register index returns; upper bits read zero
  function automatic logic [31:0] readMux(input logic [7:0]  a,
                                          input state_t      s,
                                          input logic [7:0]  spiByte,
                                          input logic [15:0] vec);
    logic [31:0] d;
    d = '0;
    if (a == TIMER_AND_PIN_IRQ_CONTROL_IDX) begin
      d[7:0] = s.timerCtl;
    end else if (a == TWO_WIRE_CONTROL_IDX) begin
      d[TWO_WIRE_BIT] = s.twoWireFlag;
    end else if (a == SPI_STATUS_IDX) begin
      d[SPI_DONE_BIT] = s.spiDone;
    end else if (a == SPI_DATA_REGISTER_IDX) begin
      d[7:0] = spiByte;
    end else if (a == SERIAL_PORT_CONTROL_IDX) begin
      d[7:0] = s.serialCtl;
    end else if (a == IRQ_STATUS_IDX) begin
      d[7:0] = s.status;
    end else if (a == IRQ_MASK_IDX) begin
      d[7:0] = s.mask;
    end else if (a == VECTOR_IDX) begin
      d[15:0] = vec;
    end
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // one wait cycle per access, answer on the second edge
  assign idx         = address[7:0];
  assign hit         = (address[9:8] == 2'b00) && isMapped(idx);
  assign wrEn        = write && st_r.waitPhase && byteenable[0];
  assign rdEn        = read && st_r.waitPhase;
  // read data is captured on the first edge so that it stands when waitrequest drops
  assign rdCap        = read && !st_r.waitPhase;
  assign selTimerCtl  = hit && (idx == TIMER_AND_PIN_IRQ_CONTROL_IDX);
  assign selTwoWire   = hit && (idx == TWO_WIRE_CONTROL_IDX);
  assign selSpiStatus = hit && (idx == SPI_STATUS_IDX);
  assign selSpiData   = hit && (idx == SPI_DATA_REGISTER_IDX);
  assign selSerialCtl = hit && (idx == SERIAL_PORT_CONTROL_IDX);
  assign selIrqStatus = hit && (idx == IRQ_STATUS_IDX);
  assign selIrqMask   = hit && (idx == IRQ_MASK_IDX);
  assign selVector    = hit && (idx == VECTOR_IDX);
  assign wb          = writedata[7:0];
  assign waitrequest = (read || write) && !st_r.waitPhase;
  assign readdata    = st_r.readData;
  assign response    = ((read || write) && !hit) ? 2'b11 : 2'b00;

  // uart completion events chosen by mode
  always_comb begin
    srcEvt              = '0;
    srcEvt[SRC_T1]      = events.timerOneOvf;
    srcEvt[SRC_T0]      = events.timerZeroOvf;
    srcEvt[SRC_EXT1]    = events.extOneReq;
    srcEvt[SRC_EXT0]    = events.extZeroReq;
    if (serialMode == SERIAL_MODE0) begin
      srcEvt[SRC_TX]    = events.dataBit8End && events.txActive;
      srcEvt[SRC_RX]    = events.dataBit8End && !events.txActive;
    end else begin
      srcEvt[SRC_TX]    = events.stopBitStart && events.txActive;
      srcEvt[SRC_RX]    = events.stopBitMid && !events.txActive;
    end
    srcEvt[SRC_SPI]     = events.spiDone;
    srcEvt[SRC_TWOWIRE] = events.twoWireEnter &&
                          (events.twoWireState != TWO_WIRE_IDLE_CODE);
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic tcWr;
    logic scWr;
    logic twWr;
    tcWr   = wrEn && selTimerCtl;
    scWr   = wrEn && selSerialCtl;
    twWr   = wrEn && selTwoWire;
    st_nxt = st_r;
    st_nxt.waitPhase = (read || write) && !st_r.waitPhase;

    st_nxt.timerCtl[TIMER_ONE_BIT]  = clr0Flag(st_r.timerCtl[TIMER_ONE_BIT],
      srcEvt[SRC_T1], tcWr, wb[TIMER_ONE_BIT]);
    st_nxt.timerCtl[TIMER_ZERO_BIT] = clr0Flag(st_r.timerCtl[TIMER_ZERO_BIT],
      srcEvt[SRC_T0], tcWr, wb[TIMER_ZERO_BIT]);
    st_nxt.timerCtl[EXT_ONE_BIT]    = clr0Flag(st_r.timerCtl[EXT_ONE_BIT],
      srcEvt[SRC_EXT1], tcWr, wb[EXT_ONE_BIT]);
    st_nxt.timerCtl[EXT_ZERO_BIT]   = clr0Flag(st_r.timerCtl[EXT_ZERO_BIT],
      srcEvt[SRC_EXT0], tcWr, wb[EXT_ZERO_BIT]);

    // serial flags: software clears by writing 0, hardware only sets
    st_nxt.serialCtl[TX_DONE_BIT] = clr0Flag(st_r.serialCtl[TX_DONE_BIT],
      srcEvt[SRC_TX], scWr, wb[TX_DONE_BIT]);
    st_nxt.serialCtl[RX_DONE_BIT] = clr0Flag(st_r.serialCtl[RX_DONE_BIT],
      srcEvt[SRC_RX], scWr, wb[RX_DONE_BIT]);

    st_nxt.twoWireFlag = clr0Flag(st_r.twoWireFlag, srcEvt[SRC_TWOWIRE],
      twWr, wb[TWO_WIRE_BIT]);

    // spi flag: a status read that showed the flag arms, the following data read clears
    if (rdEn && selSpiStatus && st_r.readData[SPI_DONE_BIT]) begin
      st_nxt.spiStatusRead = 1'b1;
    end else if (rdEn && selSpiData) begin
      st_nxt.spiStatusRead = 1'b0;
      if (st_r.spiStatusRead) begin
        st_nxt.spiDone = 1'b0;
      end
    end
    if (srcEvt[SRC_SPI]) begin
      st_nxt.spiDone = 1'b1;
      st_nxt.spiStatusRead = 1'b0;
    end

    // summary status: write one to clear, a new event wins
    if (wrEn && selIrqStatus) begin
      st_nxt.status = st_r.status & ~wb;
    end
    st_nxt.status = st_nxt.status | srcEvt;
    if (wrEn && selIrqMask) begin
      st_nxt.mask = wb;
    end

    // external two has no flag register; its request is held until the vector is read
    if (rdEn && selVector && (st_r.readData[15:0] == EXT_TWO_VECTOR)) begin
      st_nxt.extTwoPend = 1'b0;
    end
    if (events.extTwoReq) begin
      st_nxt.extTwoPend = 1'b1;
    end

    // unmapped indices and upper address bits read zero
    if (rdCap) begin
      st_nxt.readData = hit ? readMux(idx, st_r, spiRxData, vectorAddr) : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_r          <= '0;
    end else begin
      st_r          <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    cpuRequest              = '0;
    cpuRequest[SRC_T1]      = st_r.timerCtl[TIMER_ONE_BIT];
    cpuRequest[SRC_T0]      = st_r.timerCtl[TIMER_ZERO_BIT];
    cpuRequest[SRC_EXT1]    = st_r.timerCtl[EXT_ONE_BIT];
    cpuRequest[SRC_EXT0]    = st_r.timerCtl[EXT_ZERO_BIT];
    cpuRequest[SRC_TX]      = st_r.serialCtl[TX_DONE_BIT];
    cpuRequest[SRC_RX]      = st_r.serialCtl[RX_DONE_BIT];
    cpuRequest[SRC_SPI]     = st_r.spiDone;
    cpuRequest[SRC_TWOWIRE] = st_r.twoWireFlag;
  end

  // fixed vector for the most urgent of external zero, timer zero and external two; reset vector otherwise
  always_comb begin
    vectorAddr = RESET_VECTOR;
    if (cpuRequest[SRC_EXT0]) begin
      vectorAddr = EXT_ZERO_VECTOR;
    end else if (cpuRequest[SRC_T0]) begin
      vectorAddr = TIMER_ZERO_VECTOR;
    end else if (st_r.extTwoPend) begin
      vectorAddr = EXT_TWO_VECTOR;
    end
  end

  assign irq = |(st_r.status & st_r.mask);

endmodule

// [verilog/irq_flags_pkg.sv]
package irq_flags_pkg;

  // printed offsets are not all multiples of four: they are register indices
  localparam logic [7:0] TIMER_AND_PIN_IRQ_CONTROL_IDX = 8'h88;
  localparam logic [7:0] TWO_WIRE_CONTROL_IDX          = 8'hDC;
  localparam logic [7:0] SPI_STATUS_IDX                = 8'hE1;
  localparam logic [7:0] SPI_DATA_REGISTER_IDX         = 8'hE2;
  localparam logic [7:0] SERIAL_PORT_CONTROL_IDX       = 8'hE8;
  localparam logic [7:0] IRQ_STATUS_IDX                = 8'hF0;
  localparam logic [7:0] IRQ_MASK_IDX                  = 8'hF1;
  localparam logic [7:0] VECTOR_IDX                    = 8'hF2;

  localparam int TIMER_ONE_BIT  = 7;
  localparam int TIMER_ZERO_BIT = 5;
  localparam int EXT_ONE_BIT    = 3;
  localparam int EXT_ZERO_BIT   = 1;
  localparam int TX_DONE_BIT    = 1;
  localparam int RX_DONE_BIT    = 0;
  localparam int SPI_DONE_BIT   = 7;
  localparam int TWO_WIRE_BIT   = 7;

  localparam logic [4:0] TWO_WIRE_IDLE_CODE = 5'h1F; // status F8h >> 3

  // summary status bit positions
  localparam int NUM_SRC     = 8;
  localparam int SRC_T1      = 0;
  localparam int SRC_T0      = 1;
  localparam int SRC_EXT1    = 2;
  localparam int SRC_EXT0    = 3;
  localparam int SRC_TX      = 4;
  localparam int SRC_RX      = 5;
  localparam int SRC_SPI     = 6;
  localparam int SRC_TWOWIRE = 7;

  localparam logic [15:0] RESET_VECTOR     = 16'h0000;
  localparam logic [15:0] EXT_ZERO_VECTOR  = 16'h0003;
  localparam logic [15:0] TIMER_ZERO_VECTOR = 16'h000B;
  localparam logic [15:0] EXT_TWO_VECTOR   = 16'h0083;

  localparam logic [7:0] FLAGS_RESET = 8'h00;

  typedef enum logic [1:0] {
    SERIAL_MODE0,
    SERIAL_MODE1,
    SERIAL_MODE2,
    SERIAL_MODE3
  } serial_mode_t;

  typedef struct packed {
    logic       timerOneOvf;    // timer 1 overflow/reload pulse
    logic       timerZeroOvf;   // timer 0 overflow/reload pulse
    logic       extOneReq;      // external_interrupt_one request pulse
    logic       extZeroReq;     // external_interrupt_zero request pulse
    logic       extTwoReq;      // external_interrupt_two request pulse
    logic       dataBit8End;    // end of data bit 8 pulse
    logic       stopBitStart;   // start of stop bit pulse
    logic       stopBitMid;     // middle of stop bit pulse
    logic       txActive;       // uart frame is a transmit
    logic       spiDone;        // spi transfer finished pulse
    logic       twoWireEnter;   // two-wire state entered pulse
    logic [4:0] twoWireState;   // two-wire status code >> 3
  } event_t;

  typedef struct packed {
    logic [7:0] timerCtl;
    logic [7:0] serialCtl;
    logic       spiDone;
    logic       spiStatusRead;
    logic       twoWireFlag;
    logic       extTwoPend;
    logic [7:0] status;
    logic [7:0] mask;
    logic       waitPhase;
    logic [31:0] readData;
  } state_t;

endpackage

// [sim/irq_flags_sva.sv]
`timescale 1ns/1ps
module irq_flags_sva
  import irq_flags_pkg::*;
(
  input wire logic                   mclk,        // clock
  input wire logic                   rst_b,       // reset, active low
  input wire logic                   read,        // avalon read
  input wire logic                   write,       // avalon write
  input wire logic                   waitrequest, // avalon wait
  input irq_flags_pkg::event_t       events,      // peripheral events
  input irq_flags_pkg::serial_mode_t serialMode,  // uart mode
  input wire logic [7:0]             cpuRequest,  // per-source requests
  input wire logic [15:0]            vectorAddr   // vector
);
  // a completed bus write is the only legal way to clear a serial flag
  logic writeDone;
  assign writeDone = write && !waitrequest;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////
  a_t1_set: assert property (events.timerOneOvf |=> cpuRequest[SRC_T1])
    else $error("timer one flag not set");
  a_t0_set: assert property (events.timerZeroOvf |=> cpuRequest[SRC_T0])
    else $error("timer zero flag not set");
  a_ext1_set: assert property (events.extOneReq |=> cpuRequest[SRC_EXT1])
    else $error("pin one flag not set");
  a_ext0_set: assert property (events.extZeroReq |=> cpuRequest[SRC_EXT0])
    else $error("pin zero flag not set");
  a_ext0_vector: assert property ($rose(cpuRequest[SRC_EXT0]) |->
    vectorAddr == EXT_ZERO_VECTOR) else $error("pin zero vector wrong");
  a_tx_stop: assert property (events.txActive && serialMode != SERIAL_MODE0 &&
    events.stopBitStart |=> cpuRequest[SRC_TX]) else $error("tx done not set");
  a_rx_mode0: assert property (!events.txActive && serialMode == SERIAL_MODE0 &&
    events.dataBit8End |=> cpuRequest[SRC_RX]) else $error("rx done not set");
  a_rx_sticky: assert property (cpuRequest[SRC_RX] && !writeDone |=> cpuRequest[SRC_RX])
    else $error("rx done cleared by hardware");
  a_spi_set: assert property (events.spiDone |=> cpuRequest[SRC_SPI])
    else $error("spi flag not set");
  a_spi_hold: assert property (cpuRequest[SRC_SPI] && !read |=> cpuRequest[SRC_SPI])
    else $error("spi flag cleared without a read");
  a_tw_set: assert property (events.twoWireEnter &&
    events.twoWireState != TWO_WIRE_IDLE_CODE |=> cpuRequest[SRC_TWOWIRE])
    else $error("two-wire flag not set");
  a_tw_idle: assert property (events.twoWireEnter &&
    events.twoWireState == TWO_WIRE_IDLE_CODE && !cpuRequest[SRC_TWOWIRE]
    |=> !cpuRequest[SRC_TWOWIRE]) else $error("idle set flag");
  c_spi_clear: cover property ($fell(cpuRequest[SRC_SPI]));
  c_tw_set: cover property ($rose(cpuRequest[SRC_TWOWIRE]));
  c_ext0: cover property ($rose(cpuRequest[SRC_EXT0]));
endmodule
bind interrupt_request_flags irq_flags_sva chk (.mclk(mclk), .rst_b(rst_b), .read(read),
  .write(write), .waitrequest(waitrequest), .events(events), .serialMode(serialMode),
  .cpuRequest(cpuRequest), .vectorAddr(vectorAddr));

// [sim/cpu_entry_model.sv]
`timescale 1ns/1ps
module cpu_entry_model
  import irq_flags_pkg::*;
(
  input  wire logic        mclk,        // clock
  input  wire logic        rst_b,       // reset, active low
  input  wire logic [7:0]  cpuRequest,  // requests from the flags
  input  wire logic [15:0] vectorAddr,  // vector offered
  output logic      [15:0] entryVector  // vector of the last entry
);
  logic [7:0] seen_r;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      seen_r      <= 8'h00;
      entryVector <= RESET_VECTOR;
    end else begin
      seen_r <= cpuRequest;
      if (|(cpuRequest & ~seen_r)) begin
        entryVector <= vectorAddr;
      end
    end
  end
endmodule

// [sim/interrupt_request_flags_tb_top.sv]
`timescale 1ns/1ps
module interrupt_request_flags_tb_top;
  import irq_flags_pkg::*;
  logic         mclk = 1'b0;
  logic         rst_b = 1'b0;
  logic [9:0]   address = 10'h000;
  logic         read = 1'b0;
  logic         write = 1'b0;
  logic [31:0]  writedata = 32'h0;
  logic [31:0]  readdata;
  logic         waitrequest;
  logic [1:0]   response;
  logic [1:0]   lastResp;
  event_t       events = '0;
  serial_mode_t serialMode = SERIAL_MODE0;
  logic [7:0]   spiRxData = 8'h00;
  logic [7:0]   cpuRequest;
  logic [15:0]  vectorAddr;
  logic [15:0]  entryVector;
  logic         irq;
  logic [31:0]  seed = 32'hDF719252;
  logic [7:0]   expQ[$];
  int           fail_count = 0;
  int           checked = 0;
  logic [3:0]   byteEn = 4'h1;
  always #2.5 mclk = ~mclk;
  interrupt_request_flags dut (
    .mclk(mclk), .rst_b(rst_b), .address(address), .read(read), .write(write),
    .byteenable(byteEn), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .response(response), .events(events),
    .serialMode(serialMode), .spiRxData(spiRxData), .cpuRequest(cpuRequest),
    .vectorAddr(vectorAddr), .irq(irq));
  cpu_entry_model cpu (.mclk(mclk), .rst_b(rst_b), .cpuRequest(cpuRequest),
    .vectorAddr(vectorAddr), .entryVector(entryVector));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic end_of_test;
    if (fail_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // request held until waitrequest is sampled low; the answer is taken at that edge
  task automatic access(input logic rd, input logic [7:0] idx, input logic [7:0] data);
    @(posedge mclk);
    read      <= rd;
    write     <= !rd;
    address   <= {2'b00, idx};
    writedata <= {24'h0, data};
    do begin
      @(posedge mclk);
    end while (waitrequest);
    lastResp = response;
    read  <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    expQ.push_back(exp);
    access(1'b1, idx, 8'h00);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] data);
    access(1'b0, idx, data);
  endtask
  task automatic pulse(input event_t ev);
    @(posedge mclk);
    events <= ev;
    @(posedge mclk);
    events <= '0;
  endtask
  // compares read data at the edge where the read completes
  always @(posedge mclk) begin
    if (read && !waitrequest) begin
      check("readdata", readdata, {24'h0, expQ.pop_front()});
    end
  end
  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    end_of_test;
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    event_t e;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    rd(TIMER_AND_PIN_IRQ_CONTROL_IDX, FLAGS_RESET);
    e = '0;
    {e.timerOneOvf, e.timerZeroOvf, e.extOneReq, e.extZeroReq} = 4'hF;
    pulse(e);
    @(negedge mclk);
    check("cpuRequest", cpuRequest, 32'h0F);
    check("vectorAddr", vectorAddr, EXT_ZERO_VECTOR);
    rd(TIMER_AND_PIN_IRQ_CONTROL_IDX, 8'hAA);
    wr(TIMER_AND_PIN_IRQ_CONTROL_IDX, 8'hFF);
    rd(TIMER_AND_PIN_IRQ_CONTROL_IDX, 8'hAA);
    check("entryVector", entryVector, EXT_ZERO_VECTOR);
    check("irq", irq, 32'h0);
    wr(IRQ_MASK_IDX, 8'h01);
    @(negedge mclk);
    check("irq", irq, 32'h1);
    wr(TIMER_AND_PIN_IRQ_CONTROL_IDX, 8'h00);
    @(negedge mclk);
    check("cpuRequest", cpuRequest, 32'h0);
    wr(IRQ_STATUS_IDX, 8'hFF);
    @(negedge mclk);
    check("irq", irq, 32'h0);
    for (int m = 0; m < 4; m++) begin
      serialMode <= serial_mode_t'(m);
      for (int t = 0; t < 2; t++) begin
        e = '0;
        e.txActive = t[0];
        {e.dataBit8End, e.stopBitStart, e.stopBitMid} = {m != 0, m == 0 || t == 0, m == 0 || t == 1};
        pulse(e);
        rd(SERIAL_PORT_CONTROL_IDX, 8'h00);
        {e.dataBit8End, e.stopBitStart, e.stopBitMid} = {m == 0, m != 0 && t == 1, m != 0 && t == 0};
        pulse(e);
        rd(SERIAL_PORT_CONTROL_IDX, t[0] ? 8'h02 : 8'h01);
        wr(SERIAL_PORT_CONTROL_IDX, 8'h00);
      end
    end
    e = '0;
    e.extTwoReq = 1'b1;
    pulse(e);
    @(negedge mclk);
    check("vectorAddr", vectorAddr, EXT_TWO_VECTOR);
    rd(VECTOR_IDX, EXT_TWO_VECTOR[7:0]);
    @(negedge mclk);
    check("vectorAddr", vectorAddr, RESET_VECTOR);
    seed = xorshift(seed);
    spiRxData <= seed[7:0];
    e = '0;
    e.spiDone = 1'b1;
    pulse(e);
    wr(SPI_STATUS_IDX, 8'h00);
    rd(SPI_DATA_REGISTER_IDX, seed[7:0]);
    rd(SPI_STATUS_IDX, 8'h80);
    rd(SPI_DATA_REGISTER_IDX, seed[7:0]);
    rd(SPI_STATUS_IDX, 8'h00);
    for (int i = 0; i < 4; i++) begin
      seed = xorshift(seed);
      e = '0;
      e.twoWireEnter = 1'b1;
      e.twoWireState = TWO_WIRE_IDLE_CODE;
      pulse(e);
      rd(TWO_WIRE_CONTROL_IDX, 8'h00);
      e.twoWireState = (seed[4:0] == TWO_WIRE_IDLE_CODE) ? 5'h00 : seed[4:0];
      pulse(e);
      wr(TWO_WIRE_CONTROL_IDX, 8'h80);
      rd(TWO_WIRE_CONTROL_IDX, 8'h80);
      wr(TWO_WIRE_CONTROL_IDX, 8'h00);
      rd(TWO_WIRE_CONTROL_IDX, 8'h00);
    end
    // a write without its byte enable must not clear the flag
    pulse(e);
    byteEn <= 4'h0;
    wr(TWO_WIRE_CONTROL_IDX, 8'h00);
    rd(TWO_WIRE_CONTROL_IDX, 8'h80);
    byteEn <= 4'h1;
    rd(8'h50, 8'h00);
    check("response", lastResp, 32'h3);
    pulse(e);
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    @(negedge mclk);
    check("cpuRequest", cpuRequest, 32'h0);
    @(posedge mclk);
    end_of_test;
  end
endmodule
